// file: core/ddsc_core.sv
/*
  ddsc_core: phase accumulator, phase offset, truncation, sine table and output select.
  assumes select pins and control bits synchronous to I_CLK; tuning and offset words
  are held stable by the host that loads them.
*/
`timescale 1ns/100ps
`default_nettype none
module ddsc_core
  import ddsc_pkg::*;
#(
  parameter int SEL_DLY = SEL_LATENCY
) (
  input  wire logic               I_CLK,
  input  wire logic               I_SYS_RST,
  input  wire logic [ACC_W-1:0]   I_TUNING_WORD_A,
  input  wire logic [ACC_W-1:0]   I_TUNING_WORD_B,
  input  wire logic [PHASE_W-1:0] I_OFFSET_A,
  input  wire logic [PHASE_W-1:0] I_OFFSET_B,
  input  wire logic               I_TUNING_SELECT_PIN,
  input  wire logic               I_TUNING_SELECT_BIT,
  input  wire logic               I_OFFSET_SELECT_PIN,
  input  wire logic               I_OFFSET_SELECT_BIT,
  input  wire logic               I_PIN_CONTROL,
  input  wire logic               I_DIGITAL_OUT_ENABLE,
  input  wire logic               I_SQUARE_SOURCE_SELECT,
  input  wire logic               I_TRIANGLE_MODE,
  input  wire logic               I_COMPARATOR_IN,
  input  wire logic               I_DAC_READY,
  output logic [DAC_W-1:0]        O_DAC_CODE,
  output logic                    O_DAC_VALID,
  output logic                    O_SIGN_OUT,
  output logic                    O_SIGN_OE,
  output logic                    O_COMPARATOR_EN
);
  logic [ACC_W-1:0]   acc_q;
  logic [ACC_W-1:0]   incr;
  ddsc_sel_t          sel_now;
  ddsc_sel_t          sel_pipe_q [SEL_DLY];
  ddsc_sel_t          sel_eff;
  logic [PHASE_W-1:0] phase_q;
  logic [DAC_W-1:0]   sine_q;
  logic [DAC_W-1:0]   amp;
  logic [PHASE_W-1:0] phase_d2_q;
  logic               stall;
  logic [3:0]         warm_q;
  logic               live;
  ddsc_sample_t       samp;
  ddsc_sample_t       buf_out;
  logic               buf_ready;
  logic               buf_valid;
  logic               out_load;
  logic               out_sign_q;
  logic [DAC_W-1:0]   sine_rom [LUT_DEPTH];

  initial begin
    for (int i = 0; i < LUT_DEPTH; i++) begin
      sine_rom[i] = DAC_W'($rtoi(511.5 + 511.5 * $sin(2.0 * 3.14159265358979 * i / LUT_DEPTH)));
    end
  end

  // pins and bits share one path; the delay line holds the chosen source
  assign sel_now.tuning_sel = I_PIN_CONTROL ? I_TUNING_SELECT_PIN : I_TUNING_SELECT_BIT;
  assign sel_now.offset_sel = I_PIN_CONTROL ? I_OFFSET_SELECT_PIN : I_OFFSET_SELECT_BIT;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < SEL_DLY; i++) begin
        sel_pipe_q[i] <= '0;
      end
    end else begin
      sel_pipe_q[0] <= sel_now;
      for (int i = 1; i < SEL_DLY; i++) begin
        sel_pipe_q[i] <= sel_pipe_q[i-1];
      end
    end
  end
  assign sel_eff = sel_pipe_q[SEL_DLY-1];

  assign incr  = sel_eff.tuning_sel ? I_TUNING_WORD_B : I_TUNING_WORD_A;
  // the accumulator, phase and table stages stall on back-pressure so no sample is dropped
  assign stall = !buf_ready;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      acc_q <= ACC_RESET;
    end else if (!stall) begin
      acc_q <= acc_q + incr;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      phase_q <= '0;
    end else if (!stall) begin
      phase_q <= acc_q[ACC_W-1 -: PHASE_W]
               + (sel_eff.offset_sel ? I_OFFSET_B : I_OFFSET_A);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sine_q     <= DAC_MIDSCALE;
      phase_d2_q <= '0;
    end else if (!stall) begin
      sine_q     <= sine_rom[phase_q];
      phase_d2_q <= phase_q;
    end
  end

  // triangle folds the phase; triangle used only when digital output is off, else the sine table
  assign amp = (I_TRIANGLE_MODE && !I_DIGITAL_OUT_ENABLE)
             ? (phase_d2_q[PHASE_W-1] ? ~phase_d2_q[PHASE_W-2 -: DAC_W] : phase_d2_q[PHASE_W-2 -: DAC_W])
             : sine_q;

  // warm-up counter pads the pipe so the first word lands eight clocks after release;
  // the buffer and the output register add the last two clocks, so padding stops two short
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      warm_q <= '0;
    end else if (warm_q != 4'(OUT_LATENCY - 2)) begin
      warm_q <= warm_q + 4'h1;
    end
  end
  assign live = (warm_q == 4'(OUT_LATENCY - 2));

  assign samp.code = live ? amp : DAC_MIDSCALE;
  assign samp.sign = phase_d2_q[PHASE_W-1];

  ddsc_skid #(
    .W ($bits(ddsc_sample_t))
  ) u_skid (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_data  (samp),
    .i_valid (1'b1),
    .o_ready (buf_ready),
    .o_data  (buf_out),
    .o_valid (buf_valid),
    .i_ready (out_load)
  );

  // the output register is the last handshake stage: a word stands until the dac takes it,
  // so a refused word is neither lost nor counted twice
  assign out_load = buf_valid && (!O_DAC_VALID || I_DAC_READY);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_DAC_CODE  <= DAC_MIDSCALE;
      O_DAC_VALID <= 1'b0;
      out_sign_q  <= 1'b0;
    end else if (out_load) begin
      O_DAC_CODE  <= buf_out.code;
      O_DAC_VALID <= 1'b1;
      out_sign_q  <= buf_out.sign;
    end else if (I_DAC_READY) begin
      O_DAC_VALID <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_SIGN_OUT      <= 1'b0;
      O_SIGN_OE       <= 1'b0;
      O_COMPARATOR_EN <= 1'b0;
    end else begin
      O_COMPARATOR_EN <= I_SQUARE_SOURCE_SELECT && I_DIGITAL_OUT_ENABLE;
      O_SIGN_OE       <= I_DIGITAL_OUT_ENABLE;
      // phase msb travels with the word on the dac port so sign and code agree whenever digital output is on and the comparator is not selected
      O_SIGN_OUT      <= I_DIGITAL_OUT_ENABLE &&
                         (I_SQUARE_SOURCE_SELECT ? I_COMPARATOR_IN
                                                 : (out_load ? buf_out.sign : out_sign_q));
    end
  end

  sequence s_rst_release;
    I_SYS_RST ##1 !I_SYS_RST;
  endsequence

  a_acc_wraps_add: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !$past(stall) && !$past(I_SYS_RST) |-> acc_q == 28'($past(acc_q) + $past(incr)))
    else $error("accumulator did not add increment");
  a_sel_delay: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    sel_eff == $past(sel_now, SEL_DLY) || $past(I_SYS_RST, SEL_DLY))
    else $error("select delay wrong");
  a_tune_select: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !$past(stall) && !$past(I_SYS_RST) |-> 28'(acc_q - $past(acc_q))
      == ($past(sel_eff.tuning_sel) ? $past(I_TUNING_WORD_B) : $past(I_TUNING_WORD_A)))
    else $error("wrong tuning word");
  a_phase_offset: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !$past(stall) && !$past(I_SYS_RST) |-> phase_q == 12'($past(acc_q[27:16])
      + ($past(sel_eff.offset_sel) ? $past(I_OFFSET_B) : $past(I_OFFSET_A))))
    else $error("phase offset sum wrong");
  a_reset_midscale: assert property (@(posedge I_CLK)
    s_rst_release |-> O_DAC_CODE == DAC_MIDSCALE && acc_q == ACC_RESET)
    else $error("reset did not give midscale");
  a_warm_eight: assert property (@(posedge I_CLK)
    s_rst_release |-> !live [*6] ##1 live)
    else $error("output start latency wrong");
  a_comp_enable: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ##1 O_COMPARATOR_EN == $past(I_SQUARE_SOURCE_SELECT && I_DIGITAL_OUT_ENABLE))
    else $error("comparator enable wrong");
  a_sign_gated: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !O_SIGN_OE |-> !O_SIGN_OUT)
    else $error("sign driven while disabled");
  a_lut_stage: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !$past(stall) && !$past(I_SYS_RST) |-> sine_q == sine_rom[$past(phase_q)])
    else $error("table stage wrong");
  a_word_held: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_DAC_VALID && !I_DAC_READY |=> O_DAC_VALID && $stable(O_DAC_CODE))
    else $error("dac word changed before it was taken");
endmodule // ddsc_core
`default_nettype wire

// file: core/ddsc_pkg.sv
/*
  ddsc_pkg: constants and carrier types for the synthesizer core.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ddsc_pkg;
  localparam int ACC_W       = 28;
  localparam int PHASE_W     = 12;
  localparam int DAC_W       = 10;
  localparam int LUT_DEPTH   = 4096;
  localparam int SEL_LATENCY = 8;
  localparam int OUT_LATENCY = 8;
  localparam logic [DAC_W-1:0] DAC_MIDSCALE = 10'h200;
  localparam logic [ACC_W-1:0] ACC_RESET    = 28'h0000000;

  typedef struct packed {
    logic [DAC_W-1:0] code;
    logic             sign;
  } ddsc_sample_t;

  typedef struct packed {
    logic tuning_sel;
    logic offset_sel;
  } ddsc_sel_t;
endpackage : ddsc_pkg

// file: core/ddsc_skid.sv
/*
  ddsc_skid: two-entry buffer with valid/ready on both sides.
  assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ddsc_skid
  import ddsc_pkg::*;
#(
  parameter int W = 11
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rp_q];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  a_no_overflow: assert property (@(posedge i_clk) disable iff (i_rst) cnt_q != 2'h3)
    else $error("buffer count out of range");
endmodule // ddsc_skid
`default_nettype wire

// file: dv/ddsc_dac_model.sv
/* ddsc_dac_model: sample receiver standing in for the DAC.
   assumes the bench clock; i_stall makes it refuse words at random. */
`timescale 1ns/100ps
`default_nettype none
module ddsc_dac_model
  import ddsc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_stall,
  input  wire logic i_valid,
  input  wire logic i_sign,
  output logic      o_ready,
  output var int    o_words,
  output var int    o_breaks
);
  logic last_q;
  // a half-cycle tuning word makes every accepted sign differ from the last
  always_ff @(posedge i_clk) begin
    o_ready <= i_stall ? 1'($urandom % 2) : 1'b1;
    if (i_rst) begin
      o_words <= 0;
      o_breaks <= 0;
    end else if (i_valid && o_ready) begin
      o_words <= o_words + 1;
      last_q <= i_sign;
      if (o_words > 0 && i_sign == last_q) o_breaks <= o_breaks + 1;
    end
  end
endmodule // ddsc_dac_model
`default_nettype wire

// file: dv/ddsc_core_test.sv
/* ddsc_core_test: self-checking bench of the synthesizer core.
   assumes ddsc_pkg and the dac model; seed fixed at 28. */
`timescale 1ns/100ps
`default_nettype none
module ddsc_core_test;
  import ddsc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ACC_W-1:0] tw_a = '0, tw_b = '0;
  logic [PHASE_W-1:0] of_a = 12'h400, of_b = '0;
  logic tsp = 1'b0, tsb = 1'b0, osp = 1'b0, osb = 1'b0, pc = 1'b0, en = 1'b0;
  logic sq = 1'b0, trm = 1'b0, cmpi = 1'b0, stall = 1'b0, mclr = 1'b1;
  logic rdy, valid, sgn, oe, cen, prev;
  logic [DAC_W-1:0] code;
  int errors = 0, n_tests = 0, words, breaks, k, i, cnt;
  longint ex;
  ddsc_core dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_TUNING_WORD_A(tw_a),
    .I_TUNING_WORD_B(tw_b), .I_OFFSET_A(of_a), .I_OFFSET_B(of_b),
    .I_TUNING_SELECT_PIN(tsp), .I_TUNING_SELECT_BIT(tsb), .I_OFFSET_SELECT_PIN(osp),
    .I_OFFSET_SELECT_BIT(osb), .I_PIN_CONTROL(pc), .I_DIGITAL_OUT_ENABLE(en),
    .I_SQUARE_SOURCE_SELECT(sq), .I_TRIANGLE_MODE(trm), .I_COMPARATOR_IN(cmpi),
    .I_DAC_READY(rdy), .O_DAC_CODE(code), .O_DAC_VALID(valid), .O_SIGN_OUT(sgn),
    .O_SIGN_OE(oe), .O_COMPARATOR_EN(cen));
  ddsc_dac_model dac_u (.i_clk(clk), .i_rst(mclr), .i_stall(stall), .i_valid(valid),
    .i_sign(sgn), .o_ready(rdy), .o_words(words), .o_breaks(breaks));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp_code(input logic [DAC_W-1:0] g, input logic [DAC_W-1:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp_code({9'h000, g}, {9'h000, e});
  endtask
  task automatic wait_code(input logic [DAC_W-1:0] e);
    for (k = 0; k < 40 && code !== e; k++) cyc(1);
    cmp_code(code, e);
  endtask
  task automatic do_reset();
    rst = 1;
    cyc(8);
    cmp_code(code, DAC_MIDSCALE);
    cmp_bit(valid, 1'b0);
    rst = 0;
    // warm-up words read midscale; callers leave a zero tuning word and a quarter-turn
    // offset, so the first real word, on the eighth clock, is full scale
    for (i = 0; i < OUT_LATENCY; i++) begin
      cmp_code(code, DAC_MIDSCALE);
      cyc(1);
    end
    cmp_code(code, 10'h3FF);
    cmp_bit(valid, 1'b1);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(28));
    do_reset();
    mclr = 1'b0;
    wait_code(10'h3FF);
    // with digital output off the triangle is used: an eighth turn is a quarter of its rise
    trm = 1'b1;
    of_a = 12'h200;
    cyc(20);
    cmp_code(code, 10'h100);
    of_a = 12'h400;
    en = 1'b1;
    cyc(20);
    cmp_code(code, 10'h3FF);
    trm = 0;
    of_a = 12'hC00;
    wait_code(10'h000);
    for (i = 0; i < 8; i++) begin
      of_a = 12'($urandom);
      cyc(25);
      cmp_bit(sgn, of_a[11]);
      cmp_bit(oe, 1'b1);
    end
    of_a = 12'h000;
    of_b = 12'h800;
    for (i = 0; i < 8; i++) begin
      {pc, osp, osb} = 3'(i);
      cyc(25);
      cmp_bit(sgn, pc ? osp : osb);
    end
    {pc, osp, osb} = 3'h0;
    sq = 1;
    for (i = 0; i < 2; i++) begin
      cmpi = 1'(i);
      cyc(10);
      cmp_bit(sgn, cmpi);
      cmp_bit(cen, 1'b1);
    end
    en = 0;
    cyc(5);
    cmp_bit(cen, 1'b0);
    cmp_bit(oe, 1'b0);
    en = 1;
    sq = 0;
    cyc(5);
    cmp_bit(cen, 1'b0);
    tsb = 1;
    // msb rising edges over 512 clocks give the accumulator's wrap count
    for (i = 0; i < 4; i++) begin
      tw_b = 28'($urandom % 28'h4000000);
      cyc(30);
      cnt = 0;
      prev = sgn;
      repeat (512) begin
        cyc(1);
        if (!prev && sgn) cnt++;
        prev = sgn;
      end
      ex = (512 * longint'(tw_b)) >> 28;
      cmp_bit(cnt >= ex && cnt <= ex + 1, 1'b1);
    end
    tsb = 0;
    tw_a = 0;
    of_a = 12'h400;
    do_reset();
    tw_b = 28'h4000000;
    pc = 1;
    cyc(30);
    tsp = 1'b1;
    // the pin acts eight clocks on and the table path adds five; six quarter turns leave 3/4 phase
    for (i = 0; i < 14; i++) begin
      if (i == 6) tsp = 1'b0;
      cmp_code(code, (i < 13) ? 10'h3FF : 10'h1FF);
      cyc(1);
    end
    cyc(40);
    cmp_code(code, 10'h000);
    tw_a = 28'h8000000;
    pc = 0;
    cyc(30);
    mclr = 1;
    cyc(1);
    mclr = 0;
    stall = 1;
    cyc(300);
    stall = 0;
    cyc(5);
    cmp_bit(words > 50, 1'b1);
    cmp_bit(breaks == 0, 1'b1);
    complete_run();
  end
endmodule // ddsc_core_test
`default_nettype wire
